// file: src/siotpf_top.sv
// Safe local I/O block: output test pulsing, standard output gating, fault linking,
// input filtering with test pulse checks, all set up over an Avalon-MM slave.
// Assumes every input is synchronous to clk_in and ce_in freezes the whole block.
//
// Contract
// - Output modules pulsed in turn each logic cycle.
// - Pulse lasts multiplier times 400 microseconds.
// - Gating off ignores standard outputs, on ANDs.
// - No pulses while output test disabled.
// - Input source option forces output test on.
// - Input source option switches all outputs on.
// - Linked modules share module errors.
// - Input passed after filter time, default 10.
// - Diagnostic sample after delay, default 3.
// - Test pulses checked against external or output.
// - Six output sets plus relay set.
// - Ten two-channel input modules configured.
// - Modules 9 and 10 select digital/bumper.
// - Bumper mode gives separate channel faults.
// - Digital mode raises both channel faults.
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "siotpf_cfg.svh"

module siotpf_top #(
	parameter int N_OUT_MOD = 7,
	parameter int OUT_W     = 4,
	parameter int N_IN_MOD  = 10,
	parameter int LOGIC_CYC = `SIOTPF_LOGIC_CYC_DEF
) (
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       ce_in,
	input  wire logic [5:0]                 avs_address_in,
	input  wire logic                       avs_read_in,
	input  wire logic                       avs_write_in,
	input  wire logic [31:0]                avs_writedata_in,
	output logic      [31:0]                avs_readdata_out,
	output logic                            avs_waitrequest_out,
	input  wire logic [N_OUT_MOD*OUT_W-1:0] safe_out_in,
	input  wire logic [N_OUT_MOD*OUT_W-1:0] std_out_in,
	input  wire logic [N_OUT_MOD-1:0]       out_fault_event_in,
	output logic      [N_OUT_MOD*OUT_W-1:0] phys_out_out,
	input  wire logic [2*N_IN_MOD-1:0]      phys_in_in,
	input  wire logic                       ext_test_in,
	output logic      [2*N_IN_MOD-1:0]      in_state_out,
	output logic      [N_OUT_MOD-1:0]       out_fault_out,
	output logic      [2*N_IN_MOD-1:0]      in_fault_out
);

	localparam int NO  = N_OUT_MOD * OUT_W;
	localparam int NCH = 2 * N_IN_MOD;
	localparam int MW  = $clog2(N_OUT_MOD);
	localparam int TW  = $clog2(LOGIC_CYC + 1);
	localparam logic [11:0] PULSE_UNIT_CYC = 12'((`SIOTPF_PULSE_BASE_US * 1000
		+ `SIOTPF_CLK_PERIOD_NS - 1) / `SIOTPF_CLK_PERIOD_NS);
	localparam logic [11:0] FILT_UNIT_CYC = 12'((`SIOTPF_FILT_UNIT_US * 1000
		+ `SIOTPF_CLK_PERIOD_NS - 1) / `SIOTPF_CLK_PERIOD_NS);

	generate
		if (N_OUT_MOD < 2 || N_OUT_MOD > 8 || NO > 31 || N_IN_MOD < 10 || NCH > 31
			|| LOGIC_CYC < 2) begin : g_bad
			$error("siotpf_top: parameters outside the supported range.");
		end
	endgenerate

	// ==========================================================================
	// Avalon-MM slave: one wait cycle for every access
	logic        ack_q;
	logic [31:0] rdata_q;

	wire logic       req      = avs_read_in | avs_write_in;
	wire logic       wr_go    = avs_write_in & ack_q;
	wire logic       rd_take  = avs_read_in & ~ack_q;
	wire logic [MW-1:0] out_idx = avs_address_in[MW-1:0];
	wire logic [4:0] in_idx   = 5'(avs_address_in - `SIOTPF_REG_IN_CFG);
	wire logic       is_out   = 6'(avs_address_in - `SIOTPF_REG_OUT_CFG) < 6'(N_OUT_MOD);
	wire logic       is_in    = (avs_address_in >= `SIOTPF_REG_IN_CFG) && (in_idx < 5'(NCH));
	wire logic       wr_ofclr = wr_go && (avs_address_in == `SIOTPF_REG_OUT_FAULT);
	wire logic       wr_ifclr = wr_go && (avs_address_in == `SIOTPF_REG_IN_FAULT);
	wire logic       wr_mode  = wr_go && (avs_address_in == `SIOTPF_REG_IN_MODE);

	assign avs_waitrequest_out = req & ~ack_q;
	assign avs_readdata_out    = rdata_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
		end else if (ce_in) begin
			ack_q <= req & ~ack_q;
		end
	end

	// ==========================================================================
	// Parameter sets
	siotpf_pkg::siotpf_out_cfg_type out_cfg_q [N_OUT_MOD];
	siotpf_pkg::siotpf_in_cfg_type  in_cfg_q  [NCH];
	logic [1:0]                     in_mode_q;

	wire siotpf_pkg::siotpf_out_cfg_type out_wr = '{
		fault_link_en:           avs_writedata_in[19],
		input_src_en:            avs_writedata_in[`SIOTPF_SRC_EN_BIT],
		output_test_en:          avs_writedata_in[`SIOTPF_TEST_EN_BIT]
			| avs_writedata_in[`SIOTPF_SRC_EN_BIT],
		std_gate_en:             avs_writedata_in[16],
		pulse_length_multiplier: avs_writedata_in[15:8],
		test_interval:           avs_writedata_in[7:0]
	};

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			for (int m = 0; m < N_OUT_MOD; m++) begin
				out_cfg_q[m] <= '{`SIOTPF_LINK_DEF, 1'b0, 1'b0, 1'b0,
					`SIOTPF_MULT_DEF, `SIOTPF_INTERVAL_DEF};
			end
			for (int c = 0; c < NCH; c++) begin
				in_cfg_q[c] <= '{`SIOTPF_SRC_DEF, `SIOTPF_DELAY_DEF, `SIOTPF_FILT_DEF};
			end
			in_mode_q <= 2'h0;
		end else if (ce_in) begin
			if (wr_go && is_out) begin
				out_cfg_q[out_idx] <= out_wr;
			end
			if (wr_go && is_in) begin
				in_cfg_q[in_idx] <= siotpf_pkg::siotpf_in_cfg_type'(avs_writedata_in[20:0]);
			end
			if (wr_mode) begin
				in_mode_q <= avs_writedata_in[1:0];
			end
		end
	end

	// ==========================================================================
	// Output module state
	logic [N_OUT_MOD-1:0] out_fault_q;
	logic [N_OUT_MOD-1:0] test_en;
	logic [N_OUT_MOD-1:0] link_en;
	logic [N_OUT_MOD-1:0] pulse_vec;
	logic [NO-1:0]        phys_q;

	wire logic [N_OUT_MOD-1:0] of_clr   = wr_ofclr ? avs_writedata_in[N_OUT_MOD-1:0] : '0;
	wire logic [N_OUT_MOD-1:0] of_kept  = out_fault_q & ~of_clr;
	wire logic                 link_any = |(of_kept & link_en);
	wire logic [N_OUT_MOD-1:0] of_set   = out_fault_event_in
		| (link_en & {N_OUT_MOD{link_any}});

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			out_fault_q <= '0;
		end else if (ce_in) begin
			out_fault_q <= of_kept | of_set;
		end
	end

	// ==========================================================================
	// Logic cycle and test pulse scheduler
	siotpf_pkg::siotpf_sched_type sch_q;
	logic [TW-1:0]                tick_cnt_q;
	logic [MW-1:0]                cur_q;
	logic [19:0]                  pcnt_q;
	logic [7:0]                   pass_q [N_OUT_MOD];

	wire logic          tick     = tick_cnt_q == TW'(LOGIC_CYC - 1);
	wire logic [MW-1:0] cur_nx   = (cur_q == MW'(N_OUT_MOD - 1)) ? '0 : cur_q + MW'(1);
	wire logic [7:0]    cur_mult = out_cfg_q[cur_q].pulse_length_multiplier;
	wire logic [19:0]   plen     = siotpf_pkg::siotpf_scale((cur_mult == 8'h00) ? 8'h01
		: cur_mult, PULSE_UNIT_CYC);
	wire logic          cur_go   = test_en[cur_q] && !out_fault_q[cur_q];
	wire logic          pass_hit = pass_q[cur_q] == out_cfg_q[cur_q].test_interval;
	wire logic          start    = (sch_q == siotpf_pkg::SCH_IDLE) && tick && cur_go && pass_hit;
	// A multiplier lowered in mid-pulse must still end the pulse at once.
	wire logic          pend     = (sch_q == siotpf_pkg::SCH_PULSE) && (pcnt_q >= plen - 20'h1);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			tick_cnt_q <= '0;
		end else if (ce_in) begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + TW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sch_q  <= siotpf_pkg::SCH_IDLE;
			cur_q  <= '0;
			pcnt_q <= 20'h00000;
			for (int m = 0; m < N_OUT_MOD; m++) begin
				pass_q[m] <= 8'h00;
			end
		end else if (ce_in) begin
			unique case (sch_q)
				siotpf_pkg::SCH_IDLE: begin
					if (tick && cur_go) begin
						pass_q[cur_q] <= pass_hit ? 8'h00 : pass_q[cur_q] + 8'h01;
					end
					if (start) begin
						sch_q  <= siotpf_pkg::SCH_PULSE;
						pcnt_q <= 20'h00000;
					end else if (tick) begin
						cur_q <= cur_nx;
					end
				end
				siotpf_pkg::SCH_PULSE: begin
					pcnt_q <= pcnt_q + 20'h00001;
					if (pend) begin
						sch_q <= siotpf_pkg::SCH_IDLE;
						cur_q <= cur_nx;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Physical outputs
	logic [NO-1:0] phys_d;

	genvar gm, gb;
	generate
		for (gm = 0; gm < N_OUT_MOD; gm++) begin : g_om
			assign test_en[gm]   = out_cfg_q[gm].output_test_en | out_cfg_q[gm].input_src_en;
			assign link_en[gm]   = out_cfg_q[gm].fault_link_en;
			assign pulse_vec[gm] = (sch_q == siotpf_pkg::SCH_PULSE) && (cur_q == MW'(gm));
			for (gb = 0; gb < OUT_W; gb++) begin : g_ob
				localparam int I = gm * OUT_W + gb;
				wire logic lvl = out_cfg_q[gm].input_src_en ? 1'b1
					: out_cfg_q[gm].std_gate_en ? (safe_out_in[I] & std_out_in[I])
					: safe_out_in[I];
				assign phys_d[I] = lvl & ~out_fault_q[gm] & ~pulse_vec[gm];
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			phys_q <= '0;
		end else if (ce_in) begin
			phys_q <= phys_d;
		end
	end

	assign phys_out_out  = phys_q;
	assign out_fault_out = out_fault_q;

	// ==========================================================================
	// Input channels
	logic [NCH-1:0] ch_state;
	logic [NCH-1:0] ch_fault;
	logic [NCH-1:0] ch_set;
	logic [NCH-1:0] in_fault_q;

	// Selects the level that a channel's test pulse must follow.
	function automatic logic src_level(input logic [4:0] src, input logic [NO-1:0] outs,
		input logic ext);
		logic l;
		l = ext;
		if (src != 5'h00 && src <= 5'(NO)) begin
			l = outs[src - 5'h01];
		end
		return l;
	endfunction

	genvar gc, gj;
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_ch
			siotpf_in_chan u_chan (
				.clk_in       (clk_in),
				.rst_n_in     (rst_n_in),
				.ce_in        (ce_in),
				.raw_in       (phys_in_in[gc]),
				.expect_in    (src_level(in_cfg_q[gc].source, phys_q, ext_test_in)),
				.filt_cyc_in  (siotpf_pkg::siotpf_scale(in_cfg_q[gc].input_filter_time_a,
					FILT_UNIT_CYC)),
				.delay_cyc_in (siotpf_pkg::siotpf_scale(in_cfg_q[gc].test_sample_delay,
					FILT_UNIT_CYC)),
				.state_out    (ch_state[gc]),
				.fault_out    (ch_fault[gc])
			);
		end
		for (gj = 0; gj < N_IN_MOD; gj++) begin : g_im
			wire logic bump = (gj == 8) ? in_mode_q[0] : (gj == 9) ? in_mode_q[1] : 1'b0;
			wire logic both = ch_fault[2*gj] | ch_fault[2*gj+1];
			assign ch_set[2*gj]   = bump ? ch_fault[2*gj] : both;
			assign ch_set[2*gj+1] = bump ? ch_fault[2*gj+1] : both;
		end
	endgenerate

	wire logic [NCH-1:0] if_clr = wr_ifclr ? avs_writedata_in[NCH-1:0] : '0;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			in_fault_q <= '0;
		end else if (ce_in) begin
			in_fault_q <= (in_fault_q & ~if_clr) | ch_set;
		end
	end

	assign in_state_out = ch_state;
	assign in_fault_out = in_fault_q;

	// ==========================================================================
	// Read data
	wire logic [31:0] rd_word =
		is_out ? 32'(out_cfg_q[out_idx])
		: is_in ? 32'(in_cfg_q[in_idx])
		: (avs_address_in == `SIOTPF_REG_IN_MODE) ? 32'(in_mode_q)
		: (avs_address_in == `SIOTPF_REG_OUT_FAULT) ? 32'(out_fault_q)
		: (avs_address_in == `SIOTPF_REG_IN_FAULT) ? 32'(in_fault_q)
		: (avs_address_in == `SIOTPF_REG_IN_STATE) ? 32'(ch_state)
		: 32'h00000000;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_q <= 32'h00000000;
		end else if (ce_in && rd_take) begin
			rdata_q <= rd_word;
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	logic [19:0] plen_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			plen_q <= 20'h00000;
		end else begin
			plen_q <= !pulse_vec[0] ? 20'h00000 : ce_in ? plen_q + 20'h00001 : plen_q;
		end
	end

	sequence s_plain0;
		ce_in && !out_fault_q[0] && !pulse_vec[0] && !out_cfg_q[0].input_src_en;
	endsequence

	chk_gate_pass: assert property (
		s_plain0 and !out_cfg_q[0].std_gate_en |=> phys_out_out[0] == $past(safe_out_in[0]))
		else $error("Ungated output does not follow the safe value.");

	chk_gate_and: assert property (
		s_plain0 and out_cfg_q[0].std_gate_en
		|=> phys_out_out[0] == $past(safe_out_in[0] & std_out_in[0]))
		else $error("Gated output is not the AND of safe and standard.");

	chk_src_on: assert property (
		ce_in && out_cfg_q[0].input_src_en && !out_fault_q[0] && !pulse_vec[0]
		|=> phys_out_out[0])
		else $error("Source option did not switch the output on.");

	chk_src_forces_en: assert property (
		ce_in && wr_go && avs_address_in == `SIOTPF_REG_OUT_CFG
		&& avs_writedata_in[`SIOTPF_SRC_EN_BIT] |=> out_cfg_q[0].output_test_en)
		else $error("Source option did not force the output test on.");

	chk_pulse_needs_en: assert property (
		$rose(pulse_vec[0]) |-> $past(test_en[0]) && $past(tick))
		else $error("Test pulse started while output test disabled.");

	chk_pass_match: assert property (
		$rose(pulse_vec[0]) |-> $past(pass_q[0] == out_cfg_q[0].test_interval))
		else $error("Pulse started before the pass counter matched.");

	chk_pulse_len: assert property (
		$fell(pulse_vec[0]) && $past(ce_in) |-> plen_q == siotpf_pkg::siotpf_scale(
			(out_cfg_q[0].pulse_length_multiplier == 8'h00) ? 8'h01
			: out_cfg_q[0].pulse_length_multiplier, PULSE_UNIT_CYC))
		else $error("Test pulse length differs from multiplier times base.");

	chk_link_spread: assert property (
		ce_in && of_kept[0] && link_en[0] && link_en[1] && !of_clr[1] |=> out_fault_q[1])
		else $error("Module error did not spread to a linked module.");

	chk_digital_pair: assert property (
		ce_in && !in_mode_q[0] && ch_fault[16] && !if_clr[17] |=> in_fault_q[17])
		else $error("Digital mode did not raise both channel faults.");

	chk_bumper_split: assert property (
		ce_in && in_mode_q[0] && ch_fault[16] && !ch_fault[17] && !in_fault_q[17]
		|=> !in_fault_q[17] && in_fault_q[16])
		else $error("Bumper mode did not keep channel faults apart.");

endmodule
`default_nettype wire

// file: src/siotpf_cfg.svh
// Constants of the safe local I/O block: register word offsets, reset values and timing.
// Assumes a 10 MHz clock; included by siotpf_top and siotpf_in_chan, not by the package.
`ifndef SIOTPF_CFG_SVH
`define SIOTPF_CFG_SVH

// ==========================================================================
// Register word offsets
`define SIOTPF_REG_OUT_CFG    6'h00
`define SIOTPF_REG_IN_MODE    6'h07
`define SIOTPF_REG_OUT_FAULT  6'h08
`define SIOTPF_REG_IN_FAULT   6'h09
`define SIOTPF_REG_IN_STATE   6'h0A
`define SIOTPF_REG_IN_CFG     6'h20

// ==========================================================================
// Field positions and reset values
`define SIOTPF_TEST_EN_BIT    17
`define SIOTPF_SRC_EN_BIT     18
`define SIOTPF_INTERVAL_DEF   8'h00
`define SIOTPF_MULT_DEF       8'h01
`define SIOTPF_LINK_DEF       1'b1
`define SIOTPF_FILT_DEF       8'h0A
`define SIOTPF_DELAY_DEF      8'h03
`define SIOTPF_SRC_DEF        5'h00

// ==========================================================================
// Timing
`define SIOTPF_CLK_PERIOD_NS  100
`define SIOTPF_PULSE_BASE_US  400
`define SIOTPF_FILT_UNIT_US   100
`define SIOTPF_LOGIC_CYC_DEF  10000

`endif

// file: src/siotpf_pkg.sv
// Types shared by the safe local I/O block.
// Assumes nothing beyond a SystemVerilog elaborator.
package siotpf_pkg;

	// ==========================================================================
	// Parameter sets
	typedef struct packed {
		logic       fault_link_en;
		logic       input_src_en;
		logic       output_test_en;
		logic       std_gate_en;
		logic [7:0] pulse_length_multiplier;
		logic [7:0] test_interval;
	} siotpf_out_cfg_type;

	typedef struct packed {
		logic [4:0] source;
		logic [7:0] test_sample_delay;
		logic [7:0] input_filter_time_a;
	} siotpf_in_cfg_type;

	typedef enum logic {
		SCH_IDLE,
		SCH_PULSE
	} siotpf_sched_type;

	// Converts a count of time units into clock cycles.
	function automatic logic [19:0] siotpf_scale(input logic [7:0] n, input logic [11:0] unit);
		logic [19:0] p;
		p = 20'(n) * 20'(unit);
		return p;
	endfunction

endpackage

// file: src/siotpf_in_chan.sv
// One safe input channel: edge filter towards the logic and delayed diagnostic sample.
// Assumes raw_in is synchronous to clk_in and the cycle counts stay static while in use.
`timescale 1ns/100ps
`default_nettype none
`include "siotpf_cfg.svh"

module siotpf_in_chan (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	input  wire logic        raw_in,
	input  wire logic        expect_in,
	input  wire logic [19:0] filt_cyc_in,
	input  wire logic [19:0] delay_cyc_in,
	output logic             state_out,
	output logic             fault_out
);

	logic        raw_q;
	logic [19:0] cnt_q;
	logic        state_q;
	logic        fault_q;

	// ==========================================================================
	// Edge timing
	wire logic        edge_seen = raw_in != raw_q;
	wire logic [19:0] cnt_nx    = (cnt_q == 20'hFFFFF) ? cnt_q : cnt_q + 20'h00001;
	wire logic        accept    = !edge_seen && (cnt_nx >= filt_cyc_in);
	wire logic        sample    = !edge_seen && (cnt_nx == delay_cyc_in);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			raw_q   <= 1'b0;
			cnt_q   <= 20'hFFFFF;
			state_q <= 1'b0;
			fault_q <= 1'b0;
		end else if (ce_in) begin
			raw_q   <= raw_in;
			cnt_q   <= edge_seen ? 20'h00000 : cnt_nx;
			state_q <= accept ? raw_in : state_q;
			fault_q <= sample && (raw_in != expect_in);
		end
	end

	assign state_out = state_q;
	assign fault_out = fault_q;

	// ==========================================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_filter_hold: assert property (
		$changed(state_q) |-> $past(ce_in) && $past(!edge_seen) && $past(cnt_nx >= filt_cyc_in))
		else $error("Filtered state changed before the filter time expired.");

	chk_sample_time: assert property (
		$rose(fault_q) |-> $past(cnt_nx == delay_cyc_in) && $past(raw_in != expect_in))
		else $error("Diagnostic sample taken at the wrong time.");

endmodule
`default_nettype wire

// file: tb/siotpf_field.sv
// Field wiring model: contacts fed from an external test pulse source, with shorts.
// Assumes the bench drives contact, short and feed levels synchronously to the clock.
`timescale 1ns/100ps
`default_nettype none

module siotpf_field (
	input  wire logic        feed_in,
	input  wire logic [19:0] contact_in,
	input  wire logic [19:0] short_in,
	output logic             ext_test_out,
	output logic [19:0]      phys_in_out
);
	// ==========================================================================
	// Wiring
	// A closed contact passes the feed level; a short pulls the input to supply.
	assign ext_test_out = feed_in;
	assign phys_in_out  = (contact_in & {20{feed_in}}) | short_in;
endmodule

`default_nettype wire

// file: tb/siotpf_top_bench.sv
// Self-checking bench of the safe local I/O block with a field wiring model.
// Assumes the Avalon slave answers by dropping waitrequest and LOGIC_CYC is shortened.
`timescale 1ns/100ps
`default_nettype none

module siotpf_top_bench;
	logic        clk_in   = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [5:0]  adr      = 6'h00;
	logic        rd       = 1'b0;
	logic        wr       = 1'b0;
	logic [31:0] wdat     = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rdq;
	logic        wreq;
	logic [27:0] safe     = 28'h0;
	logic [27:0] std      = 28'h0;
	logic [27:0] po;
	logic [6:0]  oev      = 7'h00;
	logic [6:0]  ofl;
	logic [19:0] pin;
	logic [19:0] ist;
	logic [19:0] ifl;
	logic [19:0] cont     = 20'h0;
	logic [19:0] shrt     = 20'h0;
	logic        feed     = 1'b1;
	logic        ce       = 1'b1;
	logic        ext;
	integer      seed     = 32'h6bad541c;
	integer      failures = 0;
	integer      num_checks = 0;
	integer      cyc      = 0;
	integer      lo;
	integer      gap;
	integer      i;
	integer      j;

	siotpf_top #(.LOGIC_CYC(20)) DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.safe_out_in(safe), .std_out_in(std), .out_fault_event_in(oev),
		.phys_out_out(po), .phys_in_in(pin), .ext_test_in(ext),
		.in_state_out(ist), .out_fault_out(ofl), .in_fault_out(ifl)
	);

	siotpf_field field (
		.feed_in(feed), .contact_in(cont), .short_in(shrt),
		.ext_test_out(ext), .phys_in_out(pin)
	);

	// ==========================================================================
	// Clock, timeout and helpers
	always #50 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			failures = failures + 1;
			report_and_stop();
		end
	end

	// Expected pads: faulted modules off, gated modules ANDed, others follow safe.
	function automatic logic [27:0] out_exp(input logic [27:0] s, input logic [27:0] t,
			input logic [6:0] g, input logic [6:0] f);
		logic [27:0] e;
		e = s;
		for (int m = 0; m < 7; m++) begin
			if (g[m])
				e[m*4 +: 4] = s[m*4 +: 4] & t[m*4 +: 4];
			if (f[m])
				e[m*4 +: 4] = 4'h0;
		end
		return e;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in);
		adr  <= a;
		wdat <= d;
		wr   <= w;
		rd   <= ~w;
		@(posedge clk_in);
		while (wreq !== 1'b0) @(posedge clk_in);
		rdq = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic cycles(input integer n);
		repeat (n) @(posedge clk_in);
	endtask

	// Skips a pulse already under way, then measures one whole low pulse on output 0
	// and the high gap that follows it.
	task automatic measure();
		lo  = 0;
		gap = 0;
		@(negedge clk_in);
		while (po[0] !== 1'b1) @(negedge clk_in);
		while (po[0] !== 1'b0) @(negedge clk_in);
		while (po[0] === 1'b0) begin
			lo = lo + 1;
			@(negedge clk_in);
		end
		while (po[0] === 1'b1) begin
			gap = gap + 1;
			@(negedge clk_in);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================================
	// Scenarios
	initial begin
		cycles(16);
		rst_n_in <= 1'b1;
		for (i = 0; i < 7; i++) begin
			bus(1'b0, 6'(i), 32'h0);
			check(rdq, 32'h00080100);
		end
		for (i = 0; i < 20; i++) begin
			bus(1'b0, 6'h20 + 6'(i), 32'h0);
			check(rdq, 32'h0000030A);
		end
		bus(1'b0, 6'h07, 32'h0);
		check(rdq, 32'h0);
		bus(1'b1, 6'h3F, 32'hFFFFFFFF);
		bus(1'b0, 6'h3F, 32'h0);
		check(rdq, 32'h0);
		for (i = 0; i < 2; i++) begin
			safe <= 28'($random(seed));
			std  <= 28'($random(seed));
			bus(1'b1, 6'h02, 32'h00080100 | (32'(i) << 16));
			for (j = 0; j < 5; j++) begin
				cycles(50);
				check(po, out_exp(safe, std, {4'h0, i[0], 2'h0}, 7'h00));
			end
		end
		safe <= 28'hFFFFF0F;
		bus(1'b1, 6'h01, 32'h000C01FF);
		bus(1'b0, 6'h01, 32'h0);
		check(rdq, 32'h000E01FF);
		cycles(2);
		check(po[7:4], 4'hF);
		bus(1'b1, 6'h00, 32'h00020100);
		measure();
		check(lo, 4000);
		check(gap <= 160, 1'b1);
		bus(1'b1, 6'h00, 32'h00020201);
		measure();
		check(lo, 8000);
		check(gap > 130 && gap <= 320, 1'b1);
		bus(1'b1, 6'h00, 32'h00080100);
		bus(1'b1, 6'h20, 32'h00000302);
		cont <= 20'h00001;
		cycles(1900);
		check(ist[0], 1'b0);
		cycles(200);
		check(ist[0], 1'b1);
		cycles(1000);
		check(ifl, 20'h0);
		bus(1'b1, 6'h07, 32'h1);
		feed <= 1'b0;
		cycles(3200);
		check(ifl, 20'h0);
		shrt <= 20'h10001;
		cycles(3100);
		check(ifl, 20'h10003);
		bus(1'b0, 6'h09, 32'h0);
		check(rdq, 32'h00010003);
		bus(1'b0, 6'h0A, 32'h0);
		check(rdq, 32'h00000001);
		shrt <= 20'h0;
		cycles(3100);
		bus(1'b1, 6'h09, 32'h000FFFFF);
		bus(1'b0, 6'h09, 32'h0);
		check(rdq, 32'h0);
		bus(1'b1, 6'h07, 32'h2);
		shrt <= 20'h90000;
		cycles(3100);
		check(ifl, 20'hB0000);
		bus(1'b1, 6'h05, 32'h00000100);
		oev <= 7'h04;
		cycles(1);
		oev <= 7'h00;
		cycles(3);
		check(ofl, 7'h5F);
		check(po, out_exp(safe, std, 7'h00, 7'h5F));
		ce   <= 1'b0;
		oev  <= 7'h20;
		cycles(3);
		check(ofl, 7'h5F);
		ce   <= 1'b1;
		cycles(2);
		check(ofl, 7'h7F);
		report_and_stop();
	end
endmodule

`default_nettype wire
